// [design/eebs_defs.vh]
/*
 Constants for the exception entry bus sequencer: access kinds, address
 offsets and vector table layout. Included by the sequencer and its address helper.
*/
`ifndef EEBS_DEFS_VH
`define EEBS_DEFS_VH

// Bus access kinds
`define EEBS_ACC_IDLE   2'h0
`define EEBS_ACC_READ   2'h1
`define EEBS_ACC_WRITE  2'h2

// Word step and the vector's second half
`define EEBS_WORD_STEP  32'h0000_0002
`define EEBS_VEC_HI_OFS 32'h0000_0002

// Vector table layout
`define EEBS_RST_VEC_NUM 8'h00
`define EEBS_VEC_SZ_NRM  32'h0000_0002
`define EEBS_VEC_SZ_ADV  32'h0000_0004

`endif

// [design/eebs_vec_addr.v]
/*
 Vector location helper: turns an exception number into the vector's byte
 address for normal (2-byte) or advanced (4-byte) vector tables.
 Assumes a table based at address zero.
*/
`timescale 1ns/100ps
`include "eebs_defs.vh"

module eebs_vec_addr (
  // Select
  input  wire [7:0]  vec_num,
  input  wire        adv_mode,
  // Result
  output wire [31:0] vec_loc
);

  wire [31:0] num_w;

  assign num_w   = {24'h00_0000, vec_num};
  // Table index scaled by the entry size
  assign vec_loc = adv_mode ? (num_w << 2) : (num_w << 1);

endmodule // eebs_vec_addr

// [design/eebs_seq.v]
/*
 Exception entry bus sequencer. Issues the bus cycles for reset and
 interrupt entry, normal and advanced mode, one bus cycle per clock.
 Assumes a memory bus that answers every read in the same cycle with
 rd_data (combinational), and a core that holds its inputs steady while
 busy is high.
*/
`timescale 1ns/100ps
`include "eebs_defs.vh"

module eebs_seq (
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // Core request
  input  wire        rst_req,
  input  wire        irq_req,
  input  wire [7:0]  irq_vec_num,
  input  wire        adv_mode,
  input  wire        wake,
  input  wire [31:0] pc_in,
  input  wire [31:0] sp_in,
  input  wire [15:0] ext_ctl_in,
  // Memory bus
  input  wire [15:0] rd_data,
  output reg  [1:0]  bus_acc,
  output reg  [31:0] bus_addr,
  output reg  [15:0] wr_data,
  output reg         bus_lock,
  // Status
  output reg         busy,
  output reg         done,
  output reg  [31:0] sp_out,
  output reg  [31:0] start_addr
);

  localparam [10:0] S_IDLE = 11'h001;
  localparam [10:0] S_PRE  = 11'h002;
  localparam [10:0] S_INT1 = 11'h004;
  localparam [10:0] S_PSHL = 11'h008;
  localparam [10:0] S_PSHH = 11'h010;
  localparam [10:0] S_PSHX = 11'h020;
  localparam [10:0] S_VEC0 = 11'h040;
  localparam [10:0] S_VEC1 = 11'h080;
  localparam [10:0] S_INT2 = 11'h100;
  localparam [10:0] S_CODE = 11'h200;
  localparam [10:0] S_FIN  = 11'h400;

  reg  [10:0] st_r;
  reg  [10:0] st_nxt;
  reg         is_irq_r;
  reg         adv_r;
  reg  [7:0]  vnum_r;
  reg  [31:0] pc_r;
  reg  [31:0] sp_r;
  reg  [15:0] xc_r;
  reg  [31:0] vec_r;
  reg         code2_r;
  reg  [1:0]  acc_nxt;
  reg  [31:0] addr_nxt;
  reg  [15:0] wd_nxt;
  reg         lock_nxt;
  wire [31:0] vec_loc;

  // Pre-decrement, one word
  function [31:0] push_sp;
    input [31:0] sp;
    begin
      push_sp = sp - `EEBS_WORD_STEP;
    end
  endfunction

  eebs_vec_addr u_vec (
    .vec_num  (vnum_r),
    .adv_mode (adv_r),
    .vec_loc  (vec_loc)
  );

  // Next state and the bus cycle issued in the state being entered
  always @* begin
    st_nxt   = st_r;
    acc_nxt  = `EEBS_ACC_IDLE;
    addr_nxt = 32'h0000_0000;
    wd_nxt   = 16'h0000;
    lock_nxt = 1'b0;
    case (st_r)
      S_IDLE:
        st_nxt = S_IDLE;
      S_PRE:
        st_nxt = S_INT1;
      S_INT1:
        st_nxt = is_irq_r ? S_PSHL : S_CODE;
      S_PSHL:
        st_nxt = S_PSHH;
      S_PSHH:
        st_nxt = S_PSHX;
      S_PSHX:
        st_nxt = S_VEC0;
      S_VEC0:
        st_nxt = adv_r ? S_VEC1 : (is_irq_r ? S_INT2 : S_INT1);
      S_VEC1:
        st_nxt = is_irq_r ? S_INT2 : S_INT1;
      S_INT2:
        st_nxt = S_CODE;
      S_CODE:
        st_nxt = code2_r ? S_FIN : S_CODE;
      S_FIN:
        st_nxt = S_IDLE;
      default:
        st_nxt = S_IDLE;
    endcase
    case (st_nxt)
      S_PRE: begin
        acc_nxt  = wake ? `EEBS_ACC_IDLE : `EEBS_ACC_READ;
        addr_nxt = wake ? 32'h0000_0000 : pc_in + `EEBS_WORD_STEP;
      end
      S_PSHL: begin
        acc_nxt  = `EEBS_ACC_WRITE;
        addr_nxt = push_sp(sp_r);
        wd_nxt   = pc_r[15:0];
      end
      S_PSHH: begin
        acc_nxt  = `EEBS_ACC_WRITE;
        addr_nxt = push_sp(sp_r);
        wd_nxt   = pc_r[31:16];
      end
      S_PSHX: begin
        acc_nxt  = `EEBS_ACC_WRITE;
        addr_nxt = push_sp(sp_r);
        wd_nxt   = xc_r;
      end
      S_VEC0: begin
        acc_nxt  = `EEBS_ACC_READ;
        addr_nxt = vec_loc;
        lock_nxt = adv_r & is_irq_r;
      end
      S_VEC1: begin
        acc_nxt  = `EEBS_ACC_READ;
        addr_nxt = vec_r + `EEBS_VEC_HI_OFS;
      end
      S_CODE: begin
        acc_nxt  = `EEBS_ACC_READ;
        addr_nxt = (st_r == S_CODE) ? start_addr + `EEBS_WORD_STEP
                                    : start_addr;
      end
      default: begin
        acc_nxt  = `EEBS_ACC_IDLE;
        addr_nxt = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      st_r       <= S_IDLE;
      is_irq_r   <= 1'b0;
      adv_r      <= 1'b0;
      vnum_r     <= 8'h00;
      pc_r       <= 32'h0000_0000;
      sp_r       <= 32'h0000_0000;
      xc_r       <= 16'h0000;
      vec_r      <= 32'h0000_0000;
      code2_r    <= 1'b0;
      bus_acc    <= `EEBS_ACC_IDLE;
      bus_addr   <= 32'h0000_0000;
      wr_data    <= 16'h0000;
      bus_lock   <= 1'b0;
      busy       <= 1'b0;
      done       <= 1'b0;
      sp_out     <= 32'h0000_0000;
      start_addr <= 32'h0000_0000;
    end else begin
      done <= 1'b0;
      if (st_r == S_IDLE && (rst_req || irq_req)) begin
        // Reset entry wins over an interrupt in the same cycle
        is_irq_r <= ~rst_req;
        adv_r    <= adv_mode;
        vnum_r   <= rst_req ? `EEBS_RST_VEC_NUM : irq_vec_num;
        pc_r     <= pc_in;
        sp_r     <= sp_in;
        xc_r     <= ext_ctl_in;
        code2_r  <= 1'b0;
        busy     <= 1'b1;
        if (rst_req) begin
          st_r     <= S_VEC0;
          bus_acc  <= `EEBS_ACC_READ;
          // Reset vector number is zero, so its location is zero in
          // either table size; a stale interrupt vector must not leak in
          bus_addr <= 32'h0000_0000;
          vec_r    <= 32'h0000_0000;
          bus_lock <= 1'b0;
          wr_data  <= 16'h0000;
        end else begin
          st_r     <= S_PRE;
          bus_acc  <= wake ? `EEBS_ACC_IDLE : `EEBS_ACC_READ;
          bus_addr <= wake ? 32'h0000_0000
                           : pc_in + `EEBS_WORD_STEP;
          bus_lock <= 1'b0;
          wr_data  <= 16'h0000;
        end
      end else if (st_r != S_IDLE) begin
        st_r     <= st_nxt;
        bus_acc  <= acc_nxt;
        bus_addr <= addr_nxt;
        wr_data  <= wd_nxt;
        bus_lock <= lock_nxt;
        if (st_nxt == S_PSHL || st_nxt == S_PSHH || st_nxt == S_PSHX) begin
          sp_r <= push_sp(sp_r);
        end
        if (st_nxt == S_VEC0) begin
          vec_r <= vec_loc;
        end
        // Capture the vector words as they are read
        if (st_r == S_VEC0) begin
          if (adv_r) begin
            start_addr[31:16] <= rd_data;
          end else begin
            start_addr <= {16'h0000, rd_data};
          end
        end
        if (st_r == S_VEC1) begin
          start_addr[15:0] <= rd_data;
        end
        if (st_r == S_CODE) begin
          code2_r <= 1'b1;
        end
        if (st_nxt == S_FIN) begin
          busy   <= 1'b0;
          done   <= 1'b1;
          sp_out <= sp_r;
        end
      end
    end
  end

endmodule // eebs_seq

// [test/eebs_monitor.sv]
/* Checker on the sequencer ports.
   Assumes the core holds its inputs while busy. */
`timescale 1ns/100ps
module eebs_monitor (
  // Clock, reset, request
  input wire        clk, sys_rst, rst_req, irq_req, adv_mode, wake,
  input wire [7:0]  irq_vec_num,
  input wire [31:0] pc_in, sp_in,
  input wire [15:0] ext_ctl_in, rd_data,
  // Bus and status
  input wire [1:0]  bus_acc,
  input wire [31:0] bus_addr, sp_out, start_addr,
  input wire [15:0] wr_data,
  input wire        bus_lock, busy, done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // The sequencer is idle only once busy and done are both low
  wire go_r = !busy && !done && rst_req;
  wire go_i = !busy && !done && irq_req && !rst_req;
  sequence s_code;
    bus_acc == 2'h0 ##1 bus_acc == 2'h1 && bus_addr == start_addr
    ##1 bus_acc == 2'h1 && bus_addr == start_addr + 32'h0000_0002
    ##1 done && !busy;
  endsequence
  sequence s_push;
    bus_acc == 2'h2 && bus_addr == sp_in - 32'h0000_0002
      && wr_data == pc_in[15:0]
    ##1 bus_acc == 2'h2 && bus_addr == sp_in - 32'h0000_0004
      && wr_data == pc_in[31:16]
    ##1 bus_acc == 2'h2 && bus_addr == sp_in - 32'h0000_0006
      && wr_data == ext_ctl_in;
  endsequence
  property p_rst_nrm;
    go_r && !adv_mode |=> bus_acc == 2'h1 && bus_addr == 0 ##1 s_code;
  endproperty
  property p_rst_adv;
    go_r && adv_mode |=> bus_acc == 2'h1 && bus_addr == 0
      ##1 bus_acc == 2'h1 && bus_addr == 2 ##1 s_code;
  endproperty
  property p_pre;
    go_i && !wake |=> bus_acc == 2'h1 && bus_addr == pc_in + 2 ##1 !bus_acc;
  endproperty
  property p_wake;
    go_i && wake |=> bus_acc == 2'h0 ##1 bus_acc == 2'h0;
  endproperty
  property p_push;
    go_i |=> ##2 s_push;
  endproperty
  property p_vec_n;
    go_i && !adv_mode |=> ##5 bus_acc == 2'h1
      && bus_addr == {23'h0, irq_vec_num, 1'b0} ##1 s_code;
  endproperty
  property p_vec_a;
    go_i && adv_mode |=> ##5 bus_acc == 2'h1 && bus_lock
      && bus_addr == {22'h0, irq_vec_num, 2'h0} ##1 bus_acc == 2'h1
      && !bus_lock && bus_addr == {22'h0, irq_vec_num, 2'h2} ##1 s_code;
  endproperty
  property p_lock;
    bus_lock |-> bus_acc == 2'h1 && busy;
  endproperty
  property p_done;
    done |-> !busy ##1 !done;
  endproperty
  a_rst_nrm: assert property (p_rst_nrm) else $error("reset walk");
  a_rst_adv: assert property (p_rst_adv) else $error("adv reset");
  a_pre: assert property (p_pre) else $error("prefetch");
  a_wake: assert property (p_wake) else $error("wake idle");
  a_push: assert property (p_push) else $error("push");
  a_vec_n: assert property (p_vec_n) else $error("irq vector");
  a_vec_a: assert property (p_vec_a) else $error("adv vector");
  a_lock: assert property (p_lock) else $error("lock");
  a_done: assert property (p_done) else $error("done pulse");
endmodule // eebs_monitor
bind eebs_seq eebs_monitor mon_u (.*);

// [test/eebs_mem_model.sv]
/* Memory partner: a read returns 16'h1000 plus the address at once.
   Assumes reads are one cycle; off reads it shows the inverse word. */
`timescale 1ns/100ps
module eebs_mem_model (
  // Bus
  input  wire        clk,
  input  wire [1:0]  bus_acc,
  input  wire [31:0] bus_addr,
  output wire [15:0] rd_data
);
  logic [15:0] last_r = 16'h0000;
  wire         rd     = bus_acc == 2'h1;
  assign rd_data = rd ? 16'h1000 + bus_addr[15:0] : ~last_r;
  always @(posedge clk) if (rd) last_r <= rd_data;
endmodule // eebs_mem_model

// [test/tb_top.sv]
/* Testbench: walks each entry sequence back to back.
   Assumes the memory partner answers reads in the same cycle. */
`timescale 1ns/100ps
module tb_top;
  logic clk = 0, sys_rst = 1, rst_req = 0, irq_req = 0, adv_mode = 0, wake = 0;
  logic [7:0]  irq_vec_num = 8'h05;
  logic [31:0] pc_in = 32'h0001_2344, sp_in = 32'h0000_ff00;
  logic [15:0] ext_ctl_in = 16'h0087;
  wire [15:0]  rd_data, wr_data;
  wire [1:0]   bus_acc;
  wire [31:0]  bus_addr, sp_out, start_addr;
  wire         bus_lock, busy, done;
  int n_mismatch = 0, samples_checked = 0;
  eebs_seq dut_u (.clk(clk), .sys_rst(sys_rst), .rst_req(rst_req),
    .irq_req(irq_req), .irq_vec_num(irq_vec_num), .adv_mode(adv_mode),
    .wake(wake), .pc_in(pc_in), .sp_in(sp_in), .ext_ctl_in(ext_ctl_in),
    .rd_data(rd_data), .bus_acc(bus_acc), .bus_addr(bus_addr),
    .wr_data(wr_data), .bus_lock(bus_lock), .busy(busy), .done(done),
    .sp_out(sp_out), .start_addr(start_addr));
  eebs_mem_model mem_u (.clk(clk), .bus_acc(bus_acc), .bus_addr(bus_addr),
    .rd_data(rd_data));
  initial forever #2.5 clk = ~clk;
  task chk(input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task st(input [1:0] a, input [31:0] ad, input [15:0] w);
    chk(bus_acc, a);
    chk(bus_addr, ad);
    chk(wr_data, w);
    @(negedge clk);
  endtask
  task go(input r, i, a, w);
    rst_req = r; irq_req = i; adv_mode = a; wake = w;
    @(negedge clk);
    rst_req = 0; irq_req = 0;
    chk(busy, 1);
  endtask
  task fin(input [31:0] sa);
    chk(done, 1);
    chk(busy, 0);
    chk(start_addr, sa);
    // The done cycle still refuses requests; let it pass
    @(negedge clk);
  endtask
  task t_rst_nrm;
    go(1, 1, 0, 0);
    st(1, 0, 0);
    st(0, 0, 0);
    st(1, 32'h0000_1000, 0);
    st(1, 32'h0000_1002, 0);
    fin(32'h0000_1000);
    $display("reset normal ended");
  endtask
  task t_rst_adv;
    go(1, 0, 1, 0);
    st(1, 0, 0);
    st(1, 2, 0);
    st(0, 0, 0);
    st(1, 32'h1000_1002, 0);
    st(1, 32'h1000_1004, 0);
    fin(32'h1000_1002);
    $display("reset advanced ended");
  endtask
  task t_irq_nrm;
    go(0, 1, 0, 0);
    st(1, 32'h0001_2346, 0);
    st(0, 0, 0);
    st(2, 32'h0000_fefe, 16'h2344);
    st(2, 32'h0000_fefc, 16'h0001);
    st(2, 32'h0000_fefa, 16'h0087);
    st(1, 32'h0000_000a, 0);
    st(0, 0, 0);
    st(1, 32'h0000_100a, 0);
    st(1, 32'h0000_100c, 0);
    fin(32'h0000_100a);
    chk(sp_out, 32'h0000_fefa);
    $display("irq normal ended");
  endtask
  task t_irq_adv;
    irq_vec_num = 8'h06;
    go(0, 1, 1, 1);
    st(0, 0, 0);
    st(0, 0, 0);
    st(2, 32'h0000_fefe, 16'h2344);
    st(2, 32'h0000_fefc, 16'h0001);
    st(2, 32'h0000_fefa, 16'h0087);
    chk(bus_lock, 1);
    st(1, 32'h0000_0018, 0);
    st(1, 32'h0000_001a, 0);
    st(0, 0, 0);
    st(1, 32'h1018_101a, 0);
    st(1, 32'h1018_101c, 0);
    fin(32'h1018_101a);
    $display("irq advanced ended");
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    end_of_test;
  end
  initial begin
    repeat (20) @(negedge clk);
    sys_rst = 0;
    t_rst_nrm;
    t_rst_adv;
    t_irq_nrm;
    t_irq_adv;
    t_rst_adv;
    end_of_test;
  end
endmodule // tb_top
